// ===== core/cpsh_pkg.sv
/*
 * Constants shared by the configuration pin sharing block: shared pin indices,
 * pin group masks, one-hot state and mode codes, and values after reset.
 * Assumes a single 100 MHz clock; no timing constants are needed here.
 */
package cpsh_pkg;

   // =====================================================================
   // shared pin map
   // =====================================================================
   localparam int CPSH_NPINS = 7;
   localparam int CPSH_PIN_TDO = 0;   // test out, serial target out in config
   localparam int CPSH_PIN_TDI = 1;   // test in, serial target in
   localparam int CPSH_PIN_TMS = 2;   // test mode, serial target select
   localparam int CPSH_PIN_TCK = 3;   // test clock, serial target clock
   localparam int CPSH_PIN_SDA = 4;   // two-wire data
   localparam int CPSH_PIN_SCL = 5;   // two-wire clock
   localparam int CPSH_PIN_CHAIN = 6; // daisy-chain select out

   localparam logic [6:0] CPSH_TEST_MASK = 7'h0F;
   localparam logic [6:0] CPSH_TDO_MASK = 7'h01;
   localparam logic [6:0] CPSH_SPI_DRV_MASK = 7'h01;
   localparam logic [6:0] CPSH_TWI_MASK = 7'h30;
   localparam logic [6:0] CPSH_CHAIN_MASK = 7'h40;
   localparam logic [6:0] CPSH_NONE_MASK = 7'h00;

   // =====================================================================
   // states and modes
   // =====================================================================
   typedef enum logic [6:0] {
      CPSH_IDLE     = 7'h01,
      CPSH_INIT     = 7'h02,
      CPSH_INIT_REL = 7'h04,
      CPSH_DETECT   = 7'h08,
      CPSH_LOAD     = 7'h10,
      CPSH_DONE_REL = 7'h20,
      CPSH_USER     = 7'h40
   } cpsh_state_t;

   typedef enum logic [2:0] {
      CPSH_MODE_NONE = 3'h1,
      CPSH_MODE_SPI  = 3'h2,
      CPSH_MODE_TWI  = 3'h4
   } cpsh_mode_t;

   // =====================================================================
   // values after reset
   // =====================================================================
   localparam logic [6:0] CPSH_PINS_RST = 7'h00;
   localparam logic [10:0] CPSH_SYNC_RST = 11'h7FF; // pins idle high
endpackage

// ===== core/cpsh_sync.sv
/*
 * Two-flop level synchroniser for a bundle of pin inputs.
 * Assumes the inputs are asynchronous to clk; the first stage is read only
 * by the second stage.
 */
`timescale 1ns/1ns
module cpsh_sync
   import cpsh_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [10:0] d,
   output logic [10:0] q
);

   logic [10:0] meta_r;

   // =====================================================================
   // two stages, both reset to idle-high
   // =====================================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= CPSH_SYNC_RST;
         q <= CPSH_SYNC_RST;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== core/cpsh_pin_mux.sv
/*
 * Configuration pin sharing and status-pin handshake: sequences start,
 * initialization and completion on two open-drain status pins, detects the
 * configuration port mode, and steers the seven shared pins between the
 * configuration engine, the test port, dedicated blocks and GPIO.
 * Assumes the configuration engine and user logic run on clk; all pin
 * inputs are asynchronous and are synchronised here.
 */
// Operation
// - request pin low starts configuration
// - pull init status low when starting
// - release init status after initialization finishes
// - no download while init status reads low
// - status pins are open-drain, pull low only
// - completion pin low throughout configuration
// - no wake-up while completion pin reads low
// - test select high routes pins to test port (here test out reaches pin 0 in user mode only)
// - test select low gives GPIO or function
// - bitstream selects GPIO or function per pin
// - two-wire mode uses data and clock pins
// - serial target drives out, master drives rest
// - daisy-chain mode drives chain select out
// - user mode pins act as GPIO or function
// - user mode links two-wire pins to user port
// - detect serial or two-wire mode at activation
// - user pins tri-stated with pull-down in configuration
// - unused configuration pins tri-stated during configuration
`timescale 1ns/1ns
module cpsh_pin_mux
   import cpsh_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // request and status pins
   input wire logic config_request_n,
   input wire logic init_status_n_in,
   output logic init_status_n_out,
   output logic init_status_n_oe,
   input wire logic cfg_done_n_in,
   output logic cfg_done_n_out,
   output logic cfg_done_n_oe,
   input wire logic test_select,
   // shared pins
   input wire logic [6:0] pin_in,
   output logic [6:0] pin_out,
   output logic [6:0] pin_oe,
   output logic pulldown_en,
   // configuration engine side
   input wire logic engine_init_done,
   input wire logic engine_load_done,
   input wire logic chain_en,
   input wire logic chain_select_out_n,
   input wire logic [6:0] cfg_out,
   input wire logic [6:0] cfg_oe,
   output logic download_go,
   output logic mode_spi,
   output logic mode_twi,
   output logic user_mode,
   // user side
   input wire logic [6:0] func_sel,
   input wire logic [6:0] func_out,
   input wire logic [6:0] func_oe,
   input wire logic [6:0] gpio_out,
   input wire logic [6:0] gpio_oe,
   output logic [6:0] pin_level,
   input wire logic test_out,
   input wire logic test_out_en,
   output logic test_in,
   output logic test_mode,
   output logic test_clk
);

   // =====================================================================
   // synchronised pin levels
   // =====================================================================
   logic [10:0] sync_q;
   logic [6:0] pin_s;
   logic req_n_s, init_s, done_s, test_s;
   logic scl_prev_r;

   cpsh_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({test_select, cfg_done_n_in, init_status_n_in, config_request_n, pin_in}),
      .q(sync_q)
   );

   assign pin_s = sync_q[6:0];
   assign req_n_s = sync_q[7];
   assign init_s = sync_q[8];
   assign done_s = sync_q[9];
   assign test_s = sync_q[10];

   // =====================================================================
   // sequencer
   // =====================================================================
   cpsh_state_t state_r, state_nxt;
   cpsh_mode_t mode_r, mode_nxt;
   logic in_cfg, scl_fall;

   assign in_cfg = (state_nxt != CPSH_IDLE) && (state_nxt != CPSH_USER);
   assign scl_fall = scl_prev_r && !pin_s[CPSH_PIN_SCL];

   // next state: each status release waits for its pin to read high
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CPSH_IDLE, CPSH_USER: begin
            if (!req_n_s) begin
               state_nxt = CPSH_INIT;
            end
         end
         CPSH_INIT: begin
            if (engine_init_done) begin
               state_nxt = CPSH_INIT_REL;
            end
         end
         CPSH_INIT_REL: begin
            if (init_s) begin
               state_nxt = CPSH_DETECT;
            end
         end
         CPSH_DETECT: begin
            if (mode_nxt != CPSH_MODE_NONE) begin
               state_nxt = CPSH_LOAD;
            end
         end
         CPSH_LOAD: begin
            if (engine_load_done) begin
               state_nxt = CPSH_DONE_REL;
            end
         end
         CPSH_DONE_REL: begin
            if (done_s) begin
               state_nxt = CPSH_USER;
            end
         end
         default: begin
            state_nxt = CPSH_IDLE;
         end
      endcase
   end

   // port mode: select low means serial target, a falling clock means two-wire
   always_comb begin
      mode_nxt = mode_r;
      if (state_r == CPSH_INIT) begin
         mode_nxt = CPSH_MODE_NONE;
      end else if (state_r == CPSH_DETECT) begin
         if (!pin_s[CPSH_PIN_TMS]) begin
            mode_nxt = CPSH_MODE_SPI;
         end else if (scl_fall) begin
            mode_nxt = CPSH_MODE_TWI;
         end
      end
   end

   // =====================================================================
   // pin steering
   // =====================================================================
   logic [6:0] use_mask, cfg_oe_nxt, cfg_val_nxt, test_mask, tdo_drv;
   logic [6:0] usr_oe_nxt, usr_val_nxt, oe_nxt, val_nxt;
   logic cfg_port_on;

   // the engine only reaches pins of its own mode; others stay tri-stated
   assign cfg_port_on = (state_nxt == CPSH_DETECT) || (state_nxt == CPSH_LOAD);
   assign use_mask = (mode_nxt == CPSH_MODE_SPI) ? CPSH_SPI_DRV_MASK :
                     (mode_nxt == CPSH_MODE_TWI) ? CPSH_TWI_MASK : CPSH_NONE_MASK;
   // two-wire lines are open-drain, so the engine may only pull them low
   assign cfg_oe_nxt = ((cfg_port_on ? (cfg_oe & use_mask) : CPSH_NONE_MASK)
                       | ((in_cfg && chain_en) ? CPSH_CHAIN_MASK : CPSH_NONE_MASK));
   assign cfg_val_nxt = (mode_nxt == CPSH_MODE_TWI) ? (cfg_out & ~CPSH_TWI_MASK) : cfg_out;

   // test select takes the four test pins away from the bitstream choice
   assign test_mask = test_s ? CPSH_TEST_MASK : CPSH_NONE_MASK;
   assign tdo_drv = (test_s && test_out_en) ? CPSH_TDO_MASK : CPSH_NONE_MASK;
   assign usr_oe_nxt = (~test_mask & ((func_sel & func_oe) | (~func_sel & gpio_oe)))
                       | tdo_drv;
   assign usr_val_nxt = (~test_mask & ((func_sel & func_out) | (~func_sel & gpio_out)))
                        | (test_out ? tdo_drv : CPSH_NONE_MASK);

   assign oe_nxt = (state_nxt == CPSH_USER) ? usr_oe_nxt : cfg_oe_nxt;
   assign val_nxt = (state_nxt == CPSH_USER) ? usr_val_nxt
                    : {chain_select_out_n, cfg_val_nxt[5:0]};

   // =====================================================================
   // registers; every output but the two constant-low status values is a flop, fed from the next state or the synchronised pins
   // =====================================================================
   logic init_oe_r, done_oe_r, pd_r, go_r, user_r;
   logic [6:0] pin_out_r, pin_oe_r, level_r;
   logic tin_r, tms_r, tck_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= CPSH_IDLE;
         mode_r <= CPSH_MODE_NONE;
         scl_prev_r <= 1'b1;
         init_oe_r <= 1'b0;
         done_oe_r <= 1'b0;
         pd_r <= 1'b1;
         go_r <= 1'b0;
         user_r <= 1'b0;
         pin_out_r <= CPSH_PINS_RST;
         pin_oe_r <= CPSH_PINS_RST;
         level_r <= CPSH_PINS_RST;
         tin_r <= 1'b0;
         tms_r <= 1'b0;
         tck_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         scl_prev_r <= pin_s[CPSH_PIN_SCL];
         init_oe_r <= (state_nxt == CPSH_INIT);
         done_oe_r <= in_cfg && (state_nxt != CPSH_DONE_REL);
         pd_r <= (state_nxt != CPSH_USER);
         go_r <= (state_nxt == CPSH_LOAD);
         user_r <= (state_nxt == CPSH_USER);
         pin_out_r <= val_nxt;
         pin_oe_r <= oe_nxt;
         level_r <= pin_s;
         tin_r <= test_s && pin_s[CPSH_PIN_TDI];
         tms_r <= test_s ? pin_s[CPSH_PIN_TMS] : 1'b1;
         tck_r <= test_s && pin_s[CPSH_PIN_TCK];
      end
   end

   // open drain: the line is only ever pulled low, never driven high
   assign init_status_n_out = 1'b0;
   assign cfg_done_n_out = 1'b0;
   assign init_status_n_oe = init_oe_r;
   assign cfg_done_n_oe = done_oe_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign pulldown_en = pd_r;
   assign download_go = go_r;
   assign mode_spi = mode_r[1]; // one-hot bit of the serial target code, straight from the flop
   assign mode_twi = mode_r[2]; // one-hot bit of the two-wire code
   assign user_mode = user_r;
   assign pin_level = level_r;
   assign test_in = tin_r;
   assign test_mode = tms_r;
   assign test_clk = tck_r;

   // =====================================================================
   // checks
   // =====================================================================
   sequence req_seen;
      ((state_r == CPSH_IDLE) || (state_r == CPSH_USER)) && !req_n_s;
   endsequence

   sequence goes_init;
      ##1 (state_r == CPSH_INIT) && init_oe_r;
   endsequence

   sequence init_released;
      (state_r == CPSH_INIT_REL) && !init_oe_r;
   endsequence

   start_req_a: assert property (@(posedge clk) disable iff (!rst_n) req_seen |-> goes_init)
      else $error("request low did not start initialization");
   init_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPSH_INIT) |-> init_oe_r && done_oe_r && !go_r)
      else $error("init status not pulled low in initialization");
   init_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_r == CPSH_INIT_REL) |-> init_released and $past(engine_init_done))
      else $error("init status not released after initialization");
   hold_dl_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(go_r) |-> $past(state_r == CPSH_DETECT) && $past(init_s, 2))
      else $error("download began while init status read low");
   twi_od_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_twi && !user_r && pin_oe_r[CPSH_PIN_SDA] |-> !pin_out_r[CPSH_PIN_SDA])
      else $error("two-wire data driven high in configuration");
   done_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPSH_INIT) || (state_r == CPSH_DETECT) || (state_r == CPSH_LOAD) |-> done_oe_r)
      else $error("completion pin released during configuration");
   wake_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(user_r) |-> $past(done_s) && $past(state_r == CPSH_DONE_REL) && !done_oe_r)
      else $error("wake-up while completion pin read low");
   test_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
      user_r && $past(test_s) |-> (pin_oe_r[3:1] == 3'h0))
      else $error("test port pins driven while test select high");
   pulldn_a: assert property (@(posedge clk) disable iff (!rst_n)
      !user_r |-> pd_r && ((pin_oe_r & ~CPSH_CHAIN_MASK & ~CPSH_TWI_MASK & ~CPSH_SPI_DRV_MASK) == 7'h00))
      else $error("user pins not floating with pull-down in configuration");
   unused_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_spi && !user_r |-> (pin_oe_r & CPSH_TWI_MASK) == 7'h00)
      else $error("unused two-wire pins driven in serial target mode");
   spi_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_spi && go_r |-> (pin_oe_r[3:1] == 3'h0))
      else $error("master-driven serial pins driven by the device");
endmodule

// ===== test/cpsh_cfg_master.sv
/*
 * Partner model: the outside configuration master and the board wiring.
 * Assumes device enables are high while driving; status lines and the
 * two-wire pins are pulled up, pins 0 and 6 weakly pulled down, pins 1..3 driven by the master.
 */
`timescale 1ns/1ns
module cpsh_cfg_master (
   input wire logic request,
   input wire logic hold_init,
   input wire logic hold_done,
   input wire logic spi_frame,
   input wire logic twi_frame,
   input wire logic init_oe,
   input wire logic done_oe,
   input wire logic [6:0] dev_out,
   input wire logic [6:0] dev_oe,
   output logic config_request_n,
   output logic init_line,
   output logic done_line,
   output logic [6:0] pins
);
   logic sclk = 1'b0;
   logic sdi = 1'b0;
   logic scl_pull = 1'b0;

   // ==========================================================
   // request and open-drain status lines
   // ==========================================================
   assign config_request_n = ~request;
   assign init_line = ~(init_oe | hold_init);
   assign done_line = ~(done_oe | hold_done);

   // link clock stands low between frames; data flips after each period
   always begin
      if (spi_frame) begin
         #62 sclk = 1'b1;
         #63 sclk = 1'b0;
         sdi = ~sdi;
      end else begin
         @(spi_frame);
      end
   end

   // start condition: data low first, clock follows later
   always @(twi_frame) scl_pull <= #250 twi_frame;

   // ==========================================================
   // pin resolution
   // ==========================================================
   // released lines fall to the pull level, never keep a stale value
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pins[i] = dev_oe[i] ? dev_out[i] : 1'b0;
      end
      if (!dev_oe[1]) pins[1] = spi_frame & sdi;
      if (!dev_oe[2]) pins[2] = ~spi_frame;
      if (!dev_oe[3]) pins[3] = sclk;
      pins[4] = ~((dev_oe[4] & ~dev_out[4]) | twi_frame);
      pins[5] = ~((dev_oe[5] & ~dev_out[5]) | scl_pull);
   end
endmodule

// ===== test/cpsh_pin_mux_bench.sv
/*
 * Self-checking bench for the pin sharing block: status handshake, mode
 * detection, steering in configuration and user mode.
 * Assumes the partner model cpsh_cfg_master on the far side.
 */
`timescale 1ns/1ns
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module cpsh_pin_mux_bench
   import cpsh_pkg::*;
();
   logic clk, rst_n, request, hold_init, hold_done, spi_frame, twi_frame, test_select;
   logic engine_init_done, engine_load_done, chain_en, chain_sel_n, test_out, test_out_en;
   logic [6:0] cfg_out, cfg_oe, func_sel, func_out, func_oe, gpio_out, gpio_oe, pins, pin_out, pin_oe, pin_level;
   logic config_request_n, init_line, done_line, init_oe, done_oe, init_n_out, done_n_out;
   logic pulldown_en, download_go, mode_spi, mode_twi, user_mode, test_mode, test_in, test_clk;
   int num_errors = 0;
   int checked = 0;

   // ==========================================================
   // instances
   // ==========================================================
   cpsh_pin_mux cpsh_pin_mux_inst (.clk(clk), .rst_n(rst_n), .config_request_n(config_request_n),
      .init_status_n_in(init_line), .init_status_n_out(init_n_out), .init_status_n_oe(init_oe),
      .cfg_done_n_in(done_line), .cfg_done_n_out(done_n_out), .cfg_done_n_oe(done_oe),
      .test_select(test_select), .pin_in(pins), .pin_out(pin_out), .pin_oe(pin_oe),
      .pulldown_en(pulldown_en), .engine_init_done(engine_init_done), .engine_load_done(engine_load_done),
      .chain_en(chain_en), .chain_select_out_n(chain_sel_n), .cfg_out(cfg_out), .cfg_oe(cfg_oe),
      .download_go(download_go), .mode_spi(mode_spi), .mode_twi(mode_twi), .user_mode(user_mode),
      .func_sel(func_sel), .func_out(func_out), .func_oe(func_oe), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .pin_level(pin_level), .test_out(test_out), .test_out_en(test_out_en),
      .test_in(test_in), .test_mode(test_mode), .test_clk(test_clk));
   cpsh_cfg_master cpsh_cfg_master_inst (.request(request), .hold_init(hold_init),
      .hold_done(hold_done), .spi_frame(spi_frame), .twi_frame(twi_frame), .init_oe(init_oe),
      .done_oe(done_oe), .dev_out(pin_out), .dev_oe(pin_oe), .config_request_n(config_request_n),
      .init_line(init_line), .done_line(done_line), .pins(pins));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic finish_test();
      $display("errors=%0d checks=%0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // bounded wait on a handshake output; running out ends the run
   task automatic wait_for(input int sel, input logic val);
      logic s;
      for (int n = 0; n < 400; n++) begin
         @(posedge clk);
         #1;
         case (sel)
            0: s = init_oe;
            1: s = done_oe;
            2: s = download_go;
            default: s = user_mode;
         endcase
         if (s === val) return;
      end
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, ~val, val);
      finish_test();
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic test_reset_state();
      `CHECK(pin_oe, CPSH_NONE_MASK)
      `CHECK({init_oe, done_oe, user_mode, download_go}, 4'h0)
      `CHECK(pulldown_en, 1'b1)
   endtask

   // serial target load while the far side stalls both status lines
   task automatic test_spi_config();
      @(posedge clk);
      request <= 1'b1;
      hold_init <= 1'b1;
      cfg_out <= 7'h55;
      cfg_oe <= 7'h7F;
      wait_for(0, 1'b1);
      `CHECK({done_oe, init_n_out}, 2'b10)
      @(posedge clk);
      request <= 1'b0;
      engine_init_done <= 1'b1;
      spi_frame <= 1'b1;
      wait_for(0, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      `CHECK({download_go, mode_spi}, 2'b00)
      @(posedge clk);
      hold_init <= 1'b0;
      wait_for(2, 1'b1);
      `CHECK({mode_spi, mode_twi}, 2'b10)
      repeat (2) @(posedge clk);
      #1;
      `CHECK(pin_oe, CPSH_SPI_DRV_MASK)
      `CHECK({pin_out[0], pulldown_en, done_oe, done_n_out}, 4'hE)
      @(posedge clk);
      hold_done <= 1'b1;
      engine_load_done <= 1'b1;
      wait_for(1, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      `CHECK(user_mode, 1'b0)
      @(posedge clk);
      hold_done <= 1'b0;
      spi_frame <= 1'b0;
      wait_for(3, 1'b1);
      `CHECK(pulldown_en, 1'b0)
      @(posedge clk);
      engine_init_done <= 1'b0;
      engine_load_done <= 1'b0;
   endtask

   // user steering per pin, then the test port taking pins 0..3
   task automatic test_user_pins();
      logic [1:0] seen;
      @(posedge clk);
      func_sel <= 7'h3F;
      func_out <= 7'h25;
      func_oe <= 7'h3F;
      gpio_out <= 7'h50;
      gpio_oe <= 7'h70;
      repeat (3) @(posedge clk);
      #1;
      `CHECK({pin_oe, pin_out}, 14'h3FE5)
      @(posedge clk);
      test_select <= 1'b1;
      test_out <= 1'b1;
      test_out_en <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      `CHECK({pin_oe, pin_out[0], test_mode}, 9'h1C7)
      `CHECK({test_in, test_clk}, 2'b00)
      `CHECK(pin_level, 7'h65)
      @(posedge clk);
      spi_frame <= 1'b1;
      test_out_en <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      `CHECK({pin_oe, test_mode}, 8'hE0)
      // the link clock and data must both reach the test port while a frame runs
      seen = 2'b00;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk);
         #1;
         seen = seen | {test_clk, test_in};
      end
      `CHECK(seen, 2'b11)
      @(posedge clk);
      spi_frame <= 1'b0;
      test_select <= 1'b0;
   endtask

   // restart from user mode into two-wire load with the chain select driven
   task automatic test_twi_chain();
      @(posedge clk);
      chain_en <= 1'b1;
      chain_sel_n <= 1'b0;
      cfg_out <= 7'h30;
      cfg_oe <= 7'h30;
      request <= 1'b1;
      wait_for(0, 1'b1);
      @(posedge clk);
      request <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHECK({pin_oe, pin_out[6], pulldown_en}, {CPSH_CHAIN_MASK, 2'b01})
      @(posedge clk);
      engine_init_done <= 1'b1;
      twi_frame <= 1'b1;
      wait_for(2, 1'b1);
      `CHECK({mode_spi, mode_twi}, 2'b01)
      repeat (2) @(posedge clk);
      #1;
      `CHECK(pin_oe, CPSH_TWI_MASK | CPSH_CHAIN_MASK)
      `CHECK(pin_out & 7'h70, 7'h00)
      `CHECK(pin_level, 7'h04)
      @(posedge clk);
      engine_load_done <= 1'b1;
      twi_frame <= 1'b0;
      wait_for(3, 1'b1);
   endtask

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      rst_n = 1'b0;
      {request, hold_init, hold_done, spi_frame, twi_frame, test_select} = 6'h00;
      {engine_init_done, engine_load_done, chain_en, chain_sel_n, test_out, test_out_en} = 6'h00;
      {cfg_out, cfg_oe, func_sel, func_out, func_oe, gpio_out, gpio_oe} = 49'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      test_reset_state();
      test_spi_config();
      test_user_pins();
      test_twi_chain();
      finish_test();
   end
endmodule
